/* receive_payload_conditioner_params.svh */
// constants for the receive payload conditioner
// assumes one framer per instance, byte-wide slot beats
// How it works
// [RL1] per-slot tests act only with payload enable
// [RL2] select 0 routes chosen framer to detector
// [RL3] E1 unframed detect takes all 32 slots
// [RL4] T1 unframed detect takes channels plus F-bit
// [RL5] T1 fractional detect and generate supported
// [RL6] trunk enable replaces byte with trunk code
// [RL7] out-of-frame auto trunks all, ignoring enable
// [RL8] E1 red auto trunk after 100 ms loss
// [RL9] T1 red alarm auto trunks all channels
// [RL10] E1 milliwatt, A-law or mu-law by bit
// [RL11] A-law milliwatt eight byte sequence
// [RL12] mu-law milliwatt eight byte sequence
// [RL13] T1 milliwatt is mu-law only
// [RL14] select 1 inserts generator, framed or unframed
// [RL15] E1 inverts msb, even, odd bits
// [RL16] T1 inverts msb and remaining bits
// [RL17] T1 fix forces signaling bit to polarity
// [RL18] conditioning methods follow fixed priority
// [RL19] signaling trunk replaces ABCD output
// [RL20] master trunk with enable replaces everything
// [RL21] E1 indirect access busy for 490 ns
// [RL22] T1 indirect access busy for 650 ns
// [RL23] software waits for busy to clear
`ifndef RECEIVE_PAYLOAD_CONDITIONER_PARAMS_SVH
`define RECEIVE_PAYLOAD_CONDITIONER_PARAMS_SVH
`define OFF_T1_PE 8'h50
`define OFF_T1_BUSY 8'h51
`define OFF_T1_ADDR 8'h52
`define OFF_T1_DATA 8'h53
`define OFF_E1_PE 8'h5C
`define OFF_E1_BUSY 8'h5D
`define OFF_E1_ADDR 8'h5E
`define OFF_E1_DATA 8'h5F
`define E1_CFG_BASE 7'h20
`define E1_TRK_BASE 7'h40
`define E1_SIG_BASE 7'h60
`define T1_CFG_BASE 7'h01
`define T1_TRK_BASE 7'h19
`define T1_SIG_BASE 7'h31
`define PE_BIT 0
`define BUSY_BIT 7
`define DIR_BIT 7
`define E1_TEST 7
`define E1_STRK 5
`define E1_ALAW 3
`define E1_MSB 2
`define E1_EVEN 1
`define E1_ODD 0
`define T1_INV 7
`define T1_DMW 5
`define T1_MSB 4
`define T1_TEST 3
`define T1_FIX 1
`define T1_STRK 7
`define TRK_BIT 6
`define E1_DMW 4
`define CLK_NS 100
`define E1_CYC_NS 490
`define T1_CYC_NS 650
`define E1_BUSY_CYC ((`E1_CYC_NS + `CLK_NS - 1) / `CLK_NS)
`define T1_BUSY_CYC ((`T1_CYC_NS + `CLK_NS - 1) / `CLK_NS)
`define RED_MS 100
`define RED_CYC (`RED_MS * 1000000 / `CLK_NS)
`define ALAW_MW 64'hB4A1A1B434212134
`define MULAW_MW 64'h9E8B8B9E1E0B0B1E
`endif

/* receive_payload_conditioner_pkg.sv */
// types for the receive payload conditioner
// assumes receive_payload_conditioner_params.svh supplies the numbers
package receive_payload_conditioner_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic [3:0] sig;
    logic [4:0] slot;
    logic fbit;
    logic frame_start;
  } rx_beat_s;
  typedef struct packed {
    logic [7:0] data;
    logic [3:0] sig;
    logic [4:0] slot;
    logic fbit;
  } out_beat_s;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [7:0] mask;
    logic fbit;
  } det_s;
  typedef struct packed {
    logic [127:0][7:0] mem;
    logic [7:0] e1_pe, t1_pe, e1_addr, t1_addr, e1_data, t1_data;
    logic busy;
    logic [3:0] busy_cnt;
    logic acc_t1;
    logic [7:0] rdata;
    det_s det;
    logic gen_used;
    logic [2:0] mw_phase;
    logic [23:0] red_cnt;
    logic red_hold;
  } receive_payload_conditioner_state_s;
endpackage : receive_payload_conditioner_pkg

/* receive_payload_conditioner.sv */
// receive payload conditioner: indirect config, slot conditioning, output FIFO
// assumes framer beats and register strobes on i_clk, no crossing needed
`timescale 1ns/100ps
`include "receive_payload_conditioner_params.svh"

module receive_payload_conditioner_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0] count;
    logic valid;
    logic ready;
  } fifo_state_s;
  fifo_state_s st;
  fifo_state_s next_st;
  logic push;
  logic pop;
  assign push = i_valid & st.ready;
  assign pop = st.valid & i_ready;
  // head always sits in mem[0] so the output is a plain flop
  always_comb begin
    next_st = st;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_st.mem[i] = st.mem[i+1];
      end
      next_st.count = st.count - CW'(1);
    end
    if (push) begin
      next_st.mem[next_st.count] = i_data;
      next_st.count = next_st.count + CW'(1);
    end
    next_st.valid = next_st.count != '0;
    next_st.ready = next_st.count != CW'(DEPTH);
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_ready = st.ready;
  assign o_valid = st.valid;
  assign o_data = st.mem[0];
endmodule : receive_payload_conditioner_fifo

module receive_payload_conditioner
  import receive_payload_conditioner_pkg::*;
#(
  parameter logic [23:0] RED_HOLD_CYC = 24'(`RED_CYC)
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_e1_mode,
  input wire logic [2:0] i_framer_id,
  input wire logic [2:0] i_pattern_framer_select,
  input wire logic i_rx_pattern_insert_select,
  input wire logic i_unframed_detect,
  input wire logic i_unframed_generate,
  input wire logic i_fractional_detect,
  input wire logic i_fractional_generate,
  input wire logic i_auto_out_of_frame_condition,
  input wire logic i_auto_red_alarm_condition,
  input wire logic i_master_trunk_condition,
  input wire logic i_frame_lost,
  input wire logic i_red_alarm,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_rx_valid,
  input wire rx_beat_s i_rx,
  output logic o_rx_ready,
  input wire logic [7:0] i_gen_data,
  output logic o_gen_used,
  output det_s o_det,
  output logic o_out_valid,
  output out_beat_s o_out,
  input wire logic i_out_ready
);
  receive_payload_conditioner_state_s st;
  receive_payload_conditioner_state_s next_st;
  logic take;
  logic pe;
  logic [6:0] cfg_idx;
  logic [6:0] trk_idx;
  logic [6:0] sig_idx;
  logic [7:0] cfg;
  logic [7:0] trk;
  logic [7:0] sigc;
  logic sel;
  logic test;
  logic extract;
  logic insert;
  logic auto_trk;
  logic master;
  logic slot_on;
  logic [7:0] mw_byte;
  logic [6:0] acc_addr;
  out_beat_s cond;
  // a part-select needs a named constant, not a bare literal
  localparam logic [63:0] ALAW_PAT = `ALAW_MW;
  localparam logic [63:0] MULAW_PAT = `MULAW_MW;

  assign take = i_rx_valid & o_rx_ready;
  assign pe = i_e1_mode ? st.e1_pe[`PE_BIT] : st.t1_pe[`PE_BIT];
  assign cfg_idx = (i_e1_mode ? `E1_CFG_BASE : `T1_CFG_BASE) + {2'b00, i_rx.slot};
  assign trk_idx = (i_e1_mode ? `E1_TRK_BASE : `T1_TRK_BASE) + {2'b00, i_rx.slot};
  assign sig_idx = (i_e1_mode ? `E1_SIG_BASE : `T1_SIG_BASE) + {2'b00, i_rx.slot};
  assign cfg = st.mem[cfg_idx];
  assign trk = st.mem[trk_idx];
  assign sigc = st.mem[sig_idx];
  assign sel = i_framer_id == i_pattern_framer_select;
  assign test = i_e1_mode ? cfg[`E1_TEST] : cfg[`T1_TEST];
  // per-slot bits count only with payload enable, and never on the F-bit
  assign slot_on = pe & ~i_rx.fbit; // RL1
  assign extract = sel & ~i_rx_pattern_insert_select & (i_unframed_detect | (slot_on & test)); // RL2 RL3 RL4
  assign insert = sel & i_rx_pattern_insert_select & (i_unframed_generate | (slot_on & test)); // RL14
  assign auto_trk = ~i_rx.fbit & ((i_auto_out_of_frame_condition & i_frame_lost) // RL7
    | (i_auto_red_alarm_condition & (i_e1_mode ? st.red_hold : i_red_alarm))); // RL8 RL9
  assign master = i_master_trunk_condition & slot_on; // RL20
  // T1 milliwatt has no law choice
  assign mw_byte = (i_e1_mode & cfg[`E1_ALAW]) ? ALAW_PAT[{st.mw_phase, 3'b000} +: 8] // RL10 RL11
    : MULAW_PAT[{st.mw_phase, 3'b000} +: 8]; // RL12 RL13
  assign acc_addr = st.acc_t1 ? st.t1_addr[6:0] : st.e1_addr[6:0];

  // data priority: extract, trunk, milliwatt, generator, inversion, fix
  always_comb begin
    cond.data = i_rx.data;
    cond.sig = i_rx.sig;
    cond.slot = i_rx.slot;
    cond.fbit = i_rx.fbit;
    if (extract) begin
      cond.data = i_rx.data; // RL18
    end else if (auto_trk | master | (slot_on & cfg[`TRK_BIT])) begin
      cond.data = trk; // RL6
    end else if (slot_on & (i_e1_mode ? cfg[`E1_DMW] : cfg[`T1_DMW])) begin
      cond.data = mw_byte;
    end else if (insert) begin
      // fractional insert leaves the robbed bit alone
      if (!i_e1_mode && i_fractional_generate && !i_unframed_generate) begin
        cond.data = {i_gen_data[7:1], i_rx.data[0]}; // RL5
      end else begin
        cond.data = i_gen_data;
      end
    end else if (slot_on && i_e1_mode) begin
      cond.data = i_rx.data ^ {cfg[`E1_MSB], 7'h00} ^ (cfg[`E1_EVEN] ? 8'hAA : 8'h00) // RL15
        ^ (cfg[`E1_ODD] ? 8'h55 : 8'h00);
    end else if (slot_on) begin
      cond.data = i_rx.data ^ {cfg[`T1_MSB], 7'h00} ^ (cfg[`T1_INV] ? 8'h7F : 8'h00); // RL16
      if (cfg[`T1_FIX]) begin
        cond.data[0] = cfg[0]; // RL17
        cond.sig = {4{cfg[0]}};
      end
    end
    if (master | (slot_on & (i_e1_mode ? cfg[`E1_STRK] : sigc[`T1_STRK]))) begin
      cond.sig = sigc[3:0]; // RL19 RL20
    end
  end

  always_comb begin
    next_st = st;
    next_st.det.valid = 1'b0;
    next_st.gen_used = 1'b0;
    // indirect access: busy counts the full access cycle
    if (st.busy) begin
      if (st.busy_cnt == 4'h1) begin
        next_st.busy = 1'b0;
        if ((st.acc_t1 ? st.t1_addr[`DIR_BIT] : st.e1_addr[`DIR_BIT])) begin
          if (st.acc_t1) begin
            next_st.t1_data = st.mem[acc_addr];
          end else begin
            next_st.e1_data = st.mem[acc_addr];
          end
        end else begin
          next_st.mem[acc_addr] = st.acc_t1 ? st.t1_data : st.e1_data;
        end
      end else begin
        next_st.busy_cnt = st.busy_cnt - 4'h1;
      end
    end
    // address and data writes made while busy are dropped
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `OFF_E1_PE: next_st.e1_pe = i_reg_wdata;
        `OFF_T1_PE: next_st.t1_pe = i_reg_wdata;
        `OFF_E1_ADDR: if (!st.busy) begin
          next_st.e1_addr = i_reg_wdata;
          next_st.busy = 1'b1;
          next_st.busy_cnt = 4'(`E1_BUSY_CYC); // RL21
          next_st.acc_t1 = 1'b0;
        end
        `OFF_T1_ADDR: if (!st.busy) begin
          next_st.t1_addr = i_reg_wdata;
          next_st.busy = 1'b1;
          next_st.busy_cnt = 4'(`T1_BUSY_CYC); // RL22
          next_st.acc_t1 = 1'b1;
        end
        `OFF_E1_DATA: if (!st.busy) begin
          next_st.e1_data = i_reg_wdata; // RL21
        end
        `OFF_T1_DATA: if (!st.busy) begin
          next_st.t1_data = i_reg_wdata;
        end
        default: ;
      endcase
    end
    unique case (i_reg_addr)
      `OFF_E1_PE: next_st.rdata = st.e1_pe;
      `OFF_T1_PE: next_st.rdata = st.t1_pe;
      `OFF_E1_BUSY, `OFF_T1_BUSY: next_st.rdata = {st.busy, 7'h00};
      `OFF_E1_ADDR: next_st.rdata = st.e1_addr;
      `OFF_T1_ADDR: next_st.rdata = st.t1_addr;
      `OFF_E1_DATA: next_st.rdata = st.e1_data;
      `OFF_T1_DATA: next_st.rdata = st.t1_data;
      default: next_st.rdata = 8'h00;
    endcase
    // loss timer for E1 red conditioning
    if (!i_frame_lost) begin
      next_st.red_cnt = 24'h000000;
      next_st.red_hold = 1'b0;
    end else if (st.red_cnt < RED_HOLD_CYC - 24'h000001) begin
      next_st.red_cnt = st.red_cnt + 24'h000001;
    end else begin
      next_st.red_hold = 1'b1; // RL8
    end
    if (take) begin
      if (i_rx.frame_start) begin
        next_st.mw_phase = st.mw_phase + 3'h1;
      end
      next_st.det.valid = extract;
      next_st.det.data = i_rx.data;
      next_st.det.fbit = i_rx.fbit;
      // fractional detect ignores the robbed bit
      next_st.det.mask = (!i_e1_mode && i_fractional_detect && !i_unframed_detect) ? 8'hFE : 8'hFF; // RL5
      next_st.gen_used = insert & ~extract;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // beats are conditioned on entry, so a stalled backplane sees the settings of arrival time
  receive_payload_conditioner_fifo #(
    .W($bits(out_beat_s)),
    .DEPTH(8)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(i_rx_valid),
    .i_data(cond),
    .o_ready(o_rx_ready),
    .o_valid(o_out_valid),
    .o_data(o_out),
    .i_ready(i_out_ready)
  );

  assign o_reg_rdata = st.rdata;
  assign o_det = st.det;
  assign o_gen_used = st.gen_used;

  logic start_e1;
  logic start_t1;
  assign start_e1 = i_reg_wr & (i_reg_addr == `OFF_E1_ADDR) & ~st.busy;
  assign start_t1 = i_reg_wr & (i_reg_addr == `OFF_T1_ADDR) & ~st.busy;

  busy_e1_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL21
    start_e1 |=> st.busy [*5] ##1 !st.busy) else $error("e1 busy length wrong");
  busy_t1_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL22
    start_t1 |=> st.busy [*7] ##1 !st.busy) else $error("t1 busy length wrong");
  busy_lock_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL21
    st.busy && i_reg_wr && i_reg_addr == `OFF_E1_ADDR |=> $stable(st.e1_addr))
    else $error("address taken while busy");
  ind_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL21
    st.busy && st.busy_cnt == 4'h1 && !st.acc_t1 && !st.e1_addr[7]
    |=> st.mem[$past(acc_addr)] == $past(st.e1_data)) else $error("indirect write lost");
  det_unf_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL3
    take && sel && !i_rx_pattern_insert_select && i_unframed_detect |=> o_det.valid
    && o_det.data == $past(i_rx.data)) else $error("unframed detect missed");
  det_pe_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL1
    take && !pe && !i_unframed_detect |=> !o_det.valid) else $error("detect without enable");
  oof_trunk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL7
    take && !extract && !i_rx.fbit && i_auto_out_of_frame_condition && i_frame_lost
    |-> cond.data == trk) else $error("oof trunk missing");
  mw_t1_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL13
    take && !i_e1_mode && !extract && !auto_trk && !master && slot_on && !cfg[6] && cfg[5]
    |-> cond.data == MULAW_PAT[{st.mw_phase, 3'b000} +: 8]) else $error("t1 milliwatt wrong");
  red_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL8
    st.red_hold |-> i_frame_lost || $past(i_frame_lost)) else $error("red hold without loss");
  slot_trunk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL6
    take && !extract && slot_on && cfg[`TRK_BIT] |-> cond.data == trk) else $error("slot trunk code missing");
  mw_alaw_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL10 RL11
    take && i_e1_mode && !extract && !auto_trk && !master && slot_on && !cfg[`TRK_BIT] && cfg[`E1_DMW]
    && cfg[`E1_ALAW] |-> cond.data == ALAW_PAT[{st.mw_phase, 3'b000} +: 8]) else $error("a-law milliwatt wrong");
  e1_invert_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL15
    take && i_e1_mode && slot_on && !extract && !insert && !auto_trk && !master && !cfg[`TRK_BIT]
    && !cfg[`E1_DMW] |-> cond.data == (i_rx.data ^ {cfg[2] ^ cfg[1], {3{cfg[0], cfg[1]}}, cfg[0]}))
    else $error("e1 inversion wrong");
  t1_fix_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL17
    take && !i_e1_mode && slot_on && !extract && !insert && !auto_trk && !master && !cfg[`TRK_BIT]
    && !cfg[`T1_DMW] && cfg[`T1_FIX] && !sigc[`T1_STRK] |-> cond.sig == {4{cfg[0]}} && cond.data[0] == cfg[0])
    else $error("t1 signaling fix wrong");
  sig_trunk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL19
    take && slot_on && (i_e1_mode ? cfg[`E1_STRK] : sigc[`T1_STRK]) |-> cond.sig == sigc[3:0])
    else $error("signaling trunk missing");
  master_trunk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL20
    take && master |-> cond.sig == sigc[3:0] && (extract || cond.data == trk)) else $error("master trunk missing");
  t1_red_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL9
    take && !i_e1_mode && i_auto_red_alarm_condition && i_red_alarm && !i_rx.fbit && !extract
    |-> cond.data == trk) else $error("t1 red trunk missing");
  gen_insert_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL14
    take && insert && !auto_trk && !master && cfg[6:4] == 3'h0 |-> cond.data[7:1] == i_gen_data[7:1])
    else $error("generator data missing");
  frac_mask_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL5
    take && extract && !i_e1_mode && i_fractional_detect && !i_unframed_detect |=> o_det.mask == 8'hFE)
    else $error("fractional mask wrong");
  fbit_detect_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL4
    take && !i_e1_mode && sel && !i_rx_pattern_insert_select && i_unframed_detect && i_rx.fbit
    |=> o_det.valid && o_det.fbit) else $error("f-bit not extracted");
  busy_e1_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) start_e1);
  insert_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) take && insert);
  fifo_full_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) !o_rx_ready);
  mw_slot_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) take && slot_on && cfg[`E1_DMW] && i_e1_mode);
  red_hold_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) st.red_hold);
endmodule : receive_payload_conditioner

/* receive_payload_conditioner_sink.sv */
// backplane-side model that takes the conditioner's output stream
// assumes the bench raises i_stall to hold the fifo full
`timescale 1ns/100ps
module receive_payload_conditioner_sink
  import receive_payload_conditioner_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_valid,
  input wire out_beat_s i_beat,
  input wire logic i_stall,
  output logic o_ready
);
  out_beat_s got[$];
  initial o_ready = 1'b0;
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      got.push_back(i_beat);
    end
    o_ready <= !i_stall;
  end
endmodule : receive_payload_conditioner_sink

/* receive_payload_conditioner_test.sv */
// bench for the receive payload conditioner
// assumes receive_payload_conditioner_sink drains the output; red hold shortened to 20 cycles
`timescale 1ns/100ps
`include "receive_payload_conditioner_params.svh"
module receive_payload_conditioner_test;
  import receive_payload_conditioner_pkg::*;
  logic clk = 0, rst_n = 0, e1 = 1, ins = 0, ufd = 0, ufg = 0, aoof = 0, ared = 0, mtk = 0;
  logic flost = 0, red = 0, wr = 0, rxv = 0, stall = 0, rxr, gu, ov, ordy, fb = 0, frd = 0, frg = 0, lastfbit;
  logic [2:0] psel = 3'h2;
  logic [7:0] ra = 8'h00, wd = 8'h00, rd, gd = 8'hC3, lastdet, lastmask;
  rx_beat_s rx = '0;
  det_s det;
  out_beat_s ob;
  int fails = 0, n_tests = 0, cyc = 0, ndet = 0, ngen = 0;
  receive_payload_conditioner #(.RED_HOLD_CYC(24'h14)) i_receive_payload_conditioner (
    .i_clk(clk), .i_rst_n(rst_n), .i_e1_mode(e1), .i_framer_id(3'h2), .i_pattern_framer_select(psel),
    .i_rx_pattern_insert_select(ins), .i_unframed_detect(ufd), .i_unframed_generate(ufg),
    .i_fractional_detect(frd), .i_fractional_generate(frg), .i_auto_out_of_frame_condition(aoof),
    .i_auto_red_alarm_condition(ared), .i_master_trunk_condition(mtk), .i_frame_lost(flost),
    .i_red_alarm(red), .i_reg_wr(wr), .i_reg_addr(ra), .i_reg_wdata(wd), .o_reg_rdata(rd),
    .i_rx_valid(rxv), .i_rx(rx), .o_rx_ready(rxr), .i_gen_data(gd), .o_gen_used(gu), .o_det(det),
    .o_out_valid(ov), .o_out(ob), .i_out_ready(ordy));
  receive_payload_conditioner_sink i_receive_payload_conditioner_sink (.i_clk(clk), .i_valid(ov), .i_beat(ob), .i_stall(stall), .o_ready(ordy));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // registered pulses are seen at the edge after they launch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (det.valid === 1'b1) begin
      ndet <= ndet + 1;
      lastdet <= det.data;
      lastmask <= det.mask;
      lastfbit <= det.fbit;
    end
    if (gu === 1'b1) begin
      ngen <= ngen + 1;
    end
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_tests++;
    if (got !== ex) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic rw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : rw
  task automatic rdreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    ra <= a;
    repeat (2) @(posedge clk);
    #1 v = rd;
  endtask : rdreg
  // data first, then address; counts the cycles busy reads high
  task automatic iacc(input logic t1, input logic [7:0] ad, input logic [7:0] d, output int nb);
    nb = 0;
    rw(t1 ? `OFF_T1_DATA : `OFF_E1_DATA, d);
    rw(t1 ? `OFF_T1_ADDR : `OFF_E1_ADDR, ad);
    ra <= t1 ? `OFF_T1_BUSY : `OFF_E1_BUSY;
    repeat (14) begin
      @(posedge clk);
      #1 nb += rd[`BUSY_BIT];
    end
  endtask : iacc
  task automatic beat(input logic [4:0] sl, input logic [7:0] d, input logic [3:0] sg, input logic fs);
    int n;
    @(posedge clk);
    rxv <= 1'b1;
    rx <= '{data: d, sig: sg, slot: sl, fbit: fb, frame_start: fs};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rxr !== 1'b1 && n < 50);
    @(posedge clk);
    rxv <= 1'b0;
  endtask : beat
  task automatic run(input string nm, input logic [4:0] sl, input logic [7:0] d, input logic [3:0] sg,
                     input logic [7:0] xd, input logic [3:0] xs);
    out_beat_s b;
    beat(sl, d, sg, 1'b0);
    repeat (4) @(posedge clk);
    b = i_receive_payload_conditioner_sink.got.size() ? i_receive_payload_conditioner_sink.got.pop_front() : 'x;
    chk(nm, xd, b.data);
    chk(nm, {4'h0, xs}, {4'h0, b.sig});
    chk(nm, {2'h0, sl, fb}, {2'h0, b.slot, b.fbit});
  endtask : run
  // the start phase is the design's choice, so any rotation of the pattern is accepted
  task automatic mw(input string nm, input logic [4:0] sl, input logic [63:0] pat);
    logic [63:0] got;
    logic [127:0] pp;
    logic hit;
    out_beat_s b;
    repeat (8) beat(sl, 8'h00, 4'h0, 1'b1);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      b = i_receive_payload_conditioner_sink.got.size() ? i_receive_payload_conditioner_sink.got.pop_front() : 'x;
      got[8*i +: 8] = b.data;
    end
    pp = {pat, pat};
    hit = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (pp[8*k +: 64] === got) hit = 1'b1;
    end
    chk(nm, 8'h01, {7'h0, hit});
  endtask : mw
  initial begin
    logic [7:0] v;
    int nb;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdreg(`OFF_E1_PE, v);
    chk("e1 enable reset", 8'h00, v);
    rdreg(8'h10, v);
    chk("unmapped read", 8'h00, v);
    rw(`OFF_E1_BUSY, 8'hFF);
    rdreg(`OFF_E1_BUSY, v);
    chk("busy read only", 8'h00, v);
    iacc(0, 8'h43, 8'h5A, nb);
    chk("e1 busy cycles", 8'(`E1_BUSY_CYC), 8'(nb));
    iacc(0, 8'hC3, 8'h00, nb);
    rdreg(`OFF_E1_DATA, v);
    chk("indirect readback", 8'h5A, v);
    iacc(0, 8'h23, 8'h40, nb);
    run("enable off", 3, 8'h11, 4'h2, 8'h11, 4'h2);
    rw(`OFF_E1_PE, 8'h01);
    run("trunk code", 3, 8'h11, 4'h2, 8'h5A, 4'h2);
    iacc(0, 8'h25, 8'h05, nb);
    run("e1 invert", 5, 8'h0F, 4'h0, 8'hDA, 4'h0);
    iacc(0, 8'h24, 8'h1F, nb);
    mw("a-law milliwatt", 4, `ALAW_MW);
    iacc(0, 8'h24, 8'h10, nb);
    mw("mu-law milliwatt", 4, `MULAW_MW);
    iacc(0, 8'h23, 8'h60, nb);
    iacc(0, 8'h63, 8'h09, nb);
    run("signaling trunk", 3, 8'h11, 4'h2, 8'h5A, 4'h9);
    iacc(0, 8'h26, 8'h80, nb);
    run("extract passes", 6, 8'h77, 4'h1, 8'h77, 4'h1);
    chk("framed detect", 8'h01, 8'(ndet));
    chk("detect data", 8'h77, lastdet);
    run("untested slot", 7, 8'h66, 4'h0, 8'h66, 4'h0);
    chk("framed skip", 8'h01, 8'(ndet));
    ufd <= 1'b1;
    run("unframed slot", 7, 8'h66, 4'h0, 8'h66, 4'h0);
    chk("unframed detect", 8'h02, 8'(ndet));
    psel <= 3'h3;
    run("other framer", 6, 8'h77, 4'h1, 8'h77, 4'h1);
    chk("framer select", 8'h02, 8'(ndet));
    psel <= 3'h2;
    ins <= 1'b1;
    ufg <= 1'b1;
    run("unframed insert", 7, 8'h66, 4'h0, 8'hC3, 4'h0);
    chk("insert pulse", 8'h01, 8'(ngen));
    ufg <= 1'b0;
    run("framed insert skip", 7, 8'h66, 4'h0, 8'h66, 4'h0);
    ins <= 1'b0;
    psel <= 3'h3;
    mtk <= 1'b1;
    run("master trunk", 5, 8'h0F, 4'hF, 8'h00, 4'h0);
    mtk <= 1'b0;
    rw(`OFF_E1_PE, 8'h00);
    aoof <= 1'b1;
    flost <= 1'b1;
    run("auto out of frame", 3, 8'h11, 4'h2, 8'h5A, 4'h2);
    aoof <= 1'b0;
    flost <= 1'b0;
    repeat (2) @(posedge clk);
    ared <= 1'b1;
    flost <= 1'b1;
    run("red not yet", 3, 8'h11, 4'h2, 8'h11, 4'h2);
    repeat (25) @(posedge clk);
    run("red after hold", 3, 8'h11, 4'h2, 8'h5A, 4'h2);
    ared <= 1'b0;
    flost <= 1'b0;
    stall <= 1'b1;
    for (int i = 0; i < 8; i++) beat(0, 8'(i), 4'h0, 1'b0);
    repeat (3) @(posedge clk);
    chk("fifo full", 8'h00, {7'h0, rxr});
    stall <= 1'b0;
    repeat (12) @(posedge clk);
    chk("fifo drained", 8'h08, 8'(i_receive_payload_conditioner_sink.got.size()));
    chk("fifo order", 8'h07, i_receive_payload_conditioner_sink.got[7].data);
    i_receive_payload_conditioner_sink.got.delete();
    e1 <= 1'b0;
    iacc(1, 8'h03, 8'h90, nb);
    chk("t1 busy cycles", 8'(`T1_BUSY_CYC), 8'(nb));
    rw(`OFF_T1_PE, 8'h01);
    run("t1 invert", 2, 8'h0F, 4'h0, 8'hF0, 4'h0);
    iacc(1, 8'h03, 8'h03, nb);
    run("t1 fix", 2, 8'h0E, 4'h0, 8'h0F, 4'hF);
    iacc(1, 8'h03, 8'h28, nb);
    mw("t1 milliwatt", 2, `MULAW_MW);
    iacc(1, 8'h1B, 8'hA5, nb);
    rw(`OFF_T1_PE, 8'h00);
    ared <= 1'b1;
    red <= 1'b1;
    run("t1 red trunk", 2, 8'h0E, 4'h0, 8'hA5, 4'h0);
    ared <= 1'b0;
    red <= 1'b0;
    rw(`OFF_T1_PE, 8'h01);
    iacc(1, 8'h05, 8'h08, nb);
    psel <= 3'h2;
    ufd <= 1'b0;
    frd <= 1'b1;
    run("t1 fractional detect", 4, 8'h0E, 4'h0, 8'h0E, 4'h0);
    chk("fractional mask", 8'hFE, lastmask);
    ins <= 1'b1;
    frg <= 1'b1;
    run("t1 fractional insert", 4, 8'h0E, 4'h0, 8'hC2, 4'h0);
    chk("t1 insert pulse", 8'h02, 8'(ngen));
    ins <= 1'b0;
    ufd <= 1'b1;
    fb <= 1'b1;
    run("t1 f-bit detect", 0, 8'h01, 4'h0, 8'h01, 4'h0);
    chk("f-bit to detector", 8'h01, {7'h0, lastfbit});
    chk("unframed mask", 8'hFF, lastmask);
    chk("t1 detect count", 8'h04, 8'(ndet));
    stop_test();
  end
endmodule : receive_payload_conditioner_test
